// ### verilog/clu_pkg.sv
package clu_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [3:0] IDX_UNIT_CONTROL      = 4'h0;
  localparam logic [3:0] IDX_SEQUENTIAL_SELECT = 4'h1;
  localparam logic [3:0] IDX_TABLE0_CONTROL_A  = 4'h5;
  localparam logic [3:0] IDX_TABLE0_CONTROL_B  = 4'h6;
  localparam logic [3:0] IDX_TABLE0_CONTROL_C  = 4'h7;
  localparam logic [3:0] IDX_TABLE0_FUNCTION   = 4'h8;
  localparam logic [3:0] IDX_TABLE1_CONTROL_A  = 4'h9;
  localparam logic [3:0] IDX_TABLE1_CONTROL_B  = 4'hA;
  localparam logic [3:0] IDX_TABLE1_CONTROL_C  = 4'hB;
  localparam logic [3:0] IDX_TABLE1_FUNCTION   = 4'hC;
  localparam logic [3:0] IDX_UNIT_STATUS       = 4'hD;

  // Field positions and writable masks.
  localparam int         UNIT_ENABLE_BIT  = 0;
  localparam int         RUN_STANDBY_BIT  = 6;
  localparam int         TBL_ENABLE_BIT   = 0;
  localparam logic [7:0] UNIT_CTRL_MASK   = 8'h41;
  localparam logic [7:0] CTRL_A_MASK      = 8'hF9;
  localparam logic [7:0] CTRL_C_MASK      = 8'h0F;
  localparam logic [7:0] SEQ_SELECT_MASK  = 8'h0F;

  // Values after reset.
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [31:0] READ_RESET      = 32'h0000_0000;

  // Output filter encodings.
  localparam logic [1:0] FILT_NONE   = 2'h0;
  localparam logic [1:0] FILT_SYNC   = 2'h1;
  localparam logic [1:0] FILT_FILTER = 2'h2;

  // Sequential element encodings.
  localparam logic [3:0] SEQ_DISABLED = 4'h0;
  localparam logic [3:0] SEQ_DFF      = 4'h1;
  localparam logic [3:0] SEQ_JK       = 4'h2;
  localparam logic [3:0] SEQ_LATCH    = 4'h3;
  localparam logic [3:0] SEQ_RS       = 4'h4;

  // Input source encodings.
  localparam logic [3:0] SRC_MASK        = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK    = 4'h1;
  localparam logic [3:0] SRC_LINK        = 4'h2;
  localparam logic [3:0] SRC_EVENT0      = 4'h3;
  localparam logic [3:0] SRC_EVENT1      = 4'h4;
  localparam logic [3:0] SRC_PIN         = 4'h5;
  localparam logic [3:0] SRC_PERIPH_BASE = 4'h6;
  localparam logic [3:0] PERIPH_COUNT    = 4'h9;

  typedef struct packed {
    logic       edge_detect_enable;
    logic       table_clock_select;
    logic [1:0] output_filter_select;
    logic       pin_output_enable;
    logic [1:0] reserved;
    logic       enable;
  } clu_ctrl_a_t;

  typedef struct packed {
    logic [3:0] input1_source_field;
    logic [3:0] input0_source_field;
  } clu_ctrl_b_t;

  typedef struct packed {
    logic [3:0] reserved;
    logic [3:0] input2_source_field;
  } clu_ctrl_c_t;

  typedef struct packed {
    clu_ctrl_a_t ctrl_a;
    clu_ctrl_b_t ctrl_b;
    clu_ctrl_c_t ctrl_c;
    logic [7:0]  truth;
  } clu_table_cfg_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } clu_avs_req_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic filt;
    logic edge_prev;
    logic pulse;
  } clu_stage_t;

  typedef struct packed {
    logic [7:0]          unit_control;
    logic [3:0]          seq_sel;
    clu_table_cfg_t [1:0] tables;
    logic                seq_out;
    logic                seq_rst_hold;
    logic [1:0]          in2_prev;
    logic                bus_ack;
    logic [31:0]         rdata;
    logic [1:0]          event_out;
  } clu_top_state_t;

endpackage

// ### verilog/clu_table.sv
`timescale 1ns/1ps
module clu_table
  import clu_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst,
  // Control.
  input  wire logic       active,
  input  wire logic       tick,
  input  wire logic [1:0] filter_sel,
  input  wire logic       edge_en,
  // Data.
  input  wire logic       raw,
  output logic            result
);

  clu_stage_t st;
  clu_stage_t next_st;
  logic       filtered;

  always_comb begin
    case (filter_sel)
      FILT_SYNC: begin
        filtered = st.sync2;
      end
      FILT_FILTER: begin
        filtered = st.filt;
      end
      default: begin
        filtered = raw;
      end
    endcase
    result = edge_en ? st.pulse : filtered;
  end

  always_comb begin
    next_st = st;
    if (!active) begin
      // Cleared on the first edge after the table drops its enable.
      next_st = '0;
    end else if (tick) begin
      next_st.sync1 = raw;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      // Two matching samples are needed, so a one-tick spike never passes.
      if (st.sync2 == st.sync3) begin
        next_st.filt = st.sync3;
      end
      next_st.edge_prev = filtered;
      next_st.pulse     = filtered & ~st.edge_prev;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// ### verilog/clu_top.sv
`timescale 1ns/1ps
// Function
// - Output filter delays a table output by two (synchronizer) or four (filter) selected-clock cycles.
// - Filter state of a table clears one cycle after the table is disabled.
// - Edge detector pulses on rising edges; software picks a filter, inverts for falling.
// - Edge detector state clears one cycle after the table is disabled.
// - Sequential element takes table, filter or edge outputs per table settings.
// - Sequential element runs on the even table's clock, peripheral or input two.
// - Disabling the even table clears the sequential element, reset held one cycle.
// - Otherwise the sequential element changes only on its clock's rising edge.
// - D flip-flop: even table is data, odd is gate; gate low holds.
// - JK: even is J, odd is K; hold, clear, set, toggle.
// - D latch: even is data, odd is gate; gate high follows data.
// - RS latch: even sets, odd resets; both high forbidden for software.
// - Clock select one makes input two clock the filter and edge detector.
// - Sequential element always uses the even table's selected clock.
// - With clock select one, input two reads as low in the truth table.
// - Table outputs are events out; incoming events feed truth-table inputs.
// - Standby without run-in-standby forces outputs of clocked tables to zero.
// - Idle sleep keeps truth tables evaluating and outputs refreshing.
// - Run-in-standby at control bit 6 keeps the peripheral clock in standby.
// - Control bit 0 enables the whole unit.
// - Input two clocks filter, edge and sequential logic during sleep too.
// - Table output is the truth bit indexed by inputs, input two most significant.
// - Sequential field: 0 off, 1 D flip-flop, 2 JK, 3 D latch, 4 RS.
// - Filter field: 0 none, 1 synchronizer, 2 filter, 3 reserved.
// - Control B, C and truth fields are writable only while the table is off; control A takes any write that keeps enable set.
module clu_top
  import clu_pkg::*;
(
  // Clock and reset.
  input  wire logic             CLOCK,
  input  wire logic             SYS_RST,
  // Avalon-MM register slave.
  input  wire clu_avs_req_t     AVS_REQ,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  // Truth-table sources.
  input  wire logic [1:0][2:0]  PIN_IN,
  input  wire logic [1:0]       EVENT_IN,
  input  wire logic [8:0]       PERIPH_IN,
  // Power state.
  input  wire logic             STANDBY,
  // Table outputs.
  output logic [1:0]            EVENT_OUT,
  output logic [1:0]            PIN_OUT,
  output logic [1:0]            PIN_OE
);

  clu_top_state_t  st;
  clu_top_state_t  next_st;
  logic            unit_en;
  logic            run_stby;
  logic            pclk_run;
  logic            seq_q;
  logic            bus_req;
  logic            wr_take;
  logic [3:0]      reg_idx;
  logic [3:0]      tbl_off;
  logic [7:0]      wr_byte;
  logic [7:0]      rd_byte;
  logic [1:0]      active;
  logic [1:0]      tick;
  logic [1:0]      raw;
  logic [1:0]      result;
  logic [1:0]      clksel;
  logic [1:0]      uses_clock;
  logic [1:0]      link_src;
  logic [1:0]      table_value;
  logic [1:0][2:0] in_val;
  logic [1:0][2:0] lut_idx;
  logic            seq_a;
  logic            seq_b;

  // Maps an input source code onto the signal it names.
  function automatic logic pick_source(input logic [3:0] code,
                                       input logic       pin,
                                       input logic       link,
                                       input logic       fb,
                                       input logic [1:0] ev,
                                       input logic [8:0] periph);
    logic [3:0] slot;
    slot = code - SRC_PERIPH_BASE;
    case (code)
      SRC_MASK: begin
        pick_source = 1'b0;
      end
      SRC_FEEDBACK: begin
        pick_source = fb;
      end
      SRC_LINK: begin
        pick_source = link;
      end
      SRC_EVENT0: begin
        pick_source = ev[0];
      end
      SRC_EVENT1: begin
        pick_source = ev[1];
      end
      SRC_PIN: begin
        pick_source = pin;
      end
      default: begin
        pick_source = (code >= SRC_PERIPH_BASE && slot < PERIPH_COUNT) ? periph[slot] : 1'b0;
      end
    endcase
  endfunction

  // Applies a byte written to one table register, honouring enable protection.
  function automatic clu_table_cfg_t write_table(input clu_table_cfg_t cfg,
                                                 input logic [1:0]     field,
                                                 input logic [7:0]     data);
    clu_table_cfg_t upd;
    upd = cfg;
    case (field)
      2'h0: begin
        if (!cfg.ctrl_a.enable || data[TBL_ENABLE_BIT]) begin
          upd.ctrl_a = clu_ctrl_a_t'(data & CTRL_A_MASK);
        end else begin
          upd.ctrl_a.enable = data[TBL_ENABLE_BIT];
        end
      end
      2'h1: begin
        if (!cfg.ctrl_a.enable) begin
          upd.ctrl_b = clu_ctrl_b_t'(data);
        end
      end
      2'h2: begin
        if (!cfg.ctrl_a.enable) begin
          upd.ctrl_c = clu_ctrl_c_t'(data & CTRL_C_MASK);
        end
      end
      default: begin
        if (!cfg.ctrl_a.enable) begin
          upd.truth = data;
        end
      end
    endcase
    return upd;
  endfunction

  // Input selection, truth-table lookup and per-table clock ticks.
  always_comb begin
    unit_en  = st.unit_control[UNIT_ENABLE_BIT];
    run_stby = st.unit_control[RUN_STANDBY_BIT];
    // STANDBY models the peripheral clock being gated off in standby sleep.
    pclk_run = ~STANDBY | run_stby;
    seq_q    = st.seq_out & unit_en & st.tables[0].ctrl_a.enable;
    link_src = {st.event_out[0], st.event_out[1]};
    for (int i = 0; i < 2; i++) begin
      active[i]    = unit_en & st.tables[i].ctrl_a.enable;
      clksel[i]    = st.tables[i].ctrl_a.table_clock_select;
      in_val[i][0] = pick_source(st.tables[i].ctrl_b.input0_source_field, PIN_IN[i][0], link_src[i],
                                 seq_q, EVENT_IN, PERIPH_IN);
      in_val[i][1] = pick_source(st.tables[i].ctrl_b.input1_source_field, PIN_IN[i][1], link_src[i],
                                 seq_q, EVENT_IN, PERIPH_IN);
      in_val[i][2] = pick_source(st.tables[i].ctrl_c.input2_source_field, PIN_IN[i][2], link_src[i],
                                 seq_q, EVENT_IN, PERIPH_IN);
      // Idle sleep leaves CLOCK running, so this lookup never pauses.
      lut_idx[i]   = {in_val[i][2] & ~clksel[i], in_val[i][1], in_val[i][0]};
      raw[i]       = st.tables[i].truth[lut_idx[i]];
      // Input two is sampled, so its clock must stay well below CLOCK.
      tick[i]      = clksel[i] ? (in_val[i][2] & ~st.in2_prev[i]) : pclk_run;
      uses_clock[i] = (st.tables[i].ctrl_a.output_filter_select != FILT_NONE) |
                      st.tables[i].ctrl_a.edge_detect_enable |
                      (st.seq_sel != SEQ_DISABLED);
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_table
    clu_table u_table (
      .clk        (CLOCK),
      .rst        (SYS_RST),
      .active     (active[g]),
      .tick       (tick[g]),
      .filter_sel (st.tables[g].ctrl_a.output_filter_select),
      .edge_en    (st.tables[g].ctrl_a.edge_detect_enable),
      .raw        (raw[g]),
      .result     (result[g])
    );
  end

  // Event values of both tables, including the standby override.
  always_comb begin
    seq_a = result[0];
    seq_b = result[1];
    for (int i = 0; i < 2; i++) begin
      table_value[i] = active[i] ? result[i] : 1'b0;
      if (i == 0 && st.seq_sel != SEQ_DISABLED) begin
        table_value[i] = seq_q;
      end
      if (!pclk_run && !clksel[i] && uses_clock[i]) begin
        table_value[i] = 1'b0;
      end
    end
  end

  // Bus decode.
  always_comb begin
    bus_req = AVS_REQ.read | AVS_REQ.write;
    reg_idx = AVS_REQ.address[5:2];
    tbl_off = reg_idx - IDX_TABLE0_CONTROL_A;
    wr_byte = AVS_REQ.writedata[7:0];
    wr_take = AVS_REQ.write & st.bus_ack & AVS_REQ.byteenable[0];
    case (reg_idx)
      IDX_UNIT_CONTROL: begin
        rd_byte = st.unit_control;
      end
      IDX_SEQUENTIAL_SELECT: begin
        rd_byte = {4'h0, st.seq_sel};
      end
      IDX_TABLE0_CONTROL_A, IDX_TABLE1_CONTROL_A: begin
        rd_byte = st.tables[tbl_off[2]].ctrl_a;
      end
      IDX_TABLE0_CONTROL_B, IDX_TABLE1_CONTROL_B: begin
        rd_byte = st.tables[tbl_off[2]].ctrl_b;
      end
      IDX_TABLE0_CONTROL_C, IDX_TABLE1_CONTROL_C: begin
        rd_byte = st.tables[tbl_off[2]].ctrl_c;
      end
      IDX_TABLE0_FUNCTION, IDX_TABLE1_FUNCTION: begin
        rd_byte = st.tables[tbl_off[2]].truth;
      end
      IDX_UNIT_STATUS: begin
        rd_byte = {5'h00, seq_q, st.event_out};
      end
      default: begin
        rd_byte = REG_RESET;
      end
    endcase
  end

  // Next-state logic of the whole unit.
  always_comb begin
    next_st          = st;
    next_st.in2_prev = {in_val[1][2], in_val[0][2]};
    next_st.event_out = table_value;

    // Sequential element, clocked by the even table's tick only.
    if (!active[0]) begin
      next_st.seq_out      = 1'b0;
      next_st.seq_rst_hold = 1'b1;
    end else if (tick[0]) begin
      if (st.seq_rst_hold) begin
        // The reset stays applied for the first clock after re-enable.
        next_st.seq_out      = 1'b0;
        next_st.seq_rst_hold = 1'b0;
      end else begin
        case (st.seq_sel)
          SEQ_DFF: begin
            if (seq_b) begin
              next_st.seq_out = seq_a;
            end
          end
          SEQ_JK: begin
            case ({seq_a, seq_b})
              2'b01: begin
                next_st.seq_out = 1'b0;
              end
              2'b10: begin
                next_st.seq_out = 1'b1;
              end
              2'b11: begin
                next_st.seq_out = ~st.seq_out;
              end
              default: begin
                next_st.seq_out = st.seq_out;
              end
            endcase
          end
          SEQ_LATCH: begin
            // Transparency is sampled on the tick, trading latch speed for one clock domain.
            if (seq_b) begin
              next_st.seq_out = seq_a;
            end
          end
          SEQ_RS: begin
            // Both inputs high is forbidden; the element simply holds.
            if (seq_a && !seq_b) begin
              next_st.seq_out = 1'b1;
            end else if (seq_b && !seq_a) begin
              next_st.seq_out = 1'b0;
            end
          end
          default: begin
            next_st.seq_out = 1'b0;
          end
        endcase
      end
    end

    // Bus slave: one wait cycle, then the access completes.
    next_st.bus_ack = bus_req & ~st.bus_ack;
    if (bus_req && !st.bus_ack) begin
      next_st.rdata = AVS_REQ.read ? {24'h00_0000, rd_byte} : READ_RESET;
    end
    if (wr_take) begin
      case (reg_idx)
        IDX_UNIT_CONTROL: begin
          next_st.unit_control = wr_byte & UNIT_CTRL_MASK;
        end
        IDX_SEQUENTIAL_SELECT: begin
          if (!st.tables[0].ctrl_a.enable) begin
            next_st.seq_sel = wr_byte[3:0] & SEQ_SELECT_MASK[3:0];
          end
        end
        IDX_TABLE0_CONTROL_A, IDX_TABLE0_CONTROL_B, IDX_TABLE0_CONTROL_C, IDX_TABLE0_FUNCTION,
        IDX_TABLE1_CONTROL_A, IDX_TABLE1_CONTROL_B, IDX_TABLE1_CONTROL_C, IDX_TABLE1_FUNCTION: begin
          next_st.tables[tbl_off[2]] = write_table(st.tables[tbl_off[2]], tbl_off[1:0], wr_byte);
        end
        default: begin
          next_st.rdata = st.rdata;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs.
  always_comb begin
    AVS_READDATA    = st.rdata;
    AVS_WAITREQUEST = bus_req & ~st.bus_ack;
    EVENT_OUT       = st.event_out;
    for (int i = 0; i < 2; i++) begin
      PIN_OE[i]  = st.tables[i].ctrl_a.pin_output_enable & active[i];
      PIN_OUT[i] = st.event_out[i] & PIN_OE[i];
    end
  end

endmodule

// ### tb/clu_top_assertions.sv
`timescale 1ns/1ps
module clu_top_assertions
  import clu_pkg::*;
(
  // Clock and reset.
  input wire logic         CLOCK,
  input wire logic         SYS_RST,
  // Register bus.
  input wire clu_avs_req_t AVS_REQ,
  input wire logic [31:0]  AVS_READDATA,
  input wire logic         AVS_WAITREQUEST,
  // Table outputs and power state.
  input wire logic         STANDBY,
  input wire logic [1:0]   EVENT_OUT,
  input wire logic [1:0]   PIN_OUT,
  input wire logic [1:0]   PIN_OE
);
  logic req;
  logic unit_en;
  assign req = AVS_REQ.read | AVS_REQ.write;
  // Shadow of the unit enable, loaded at the same edge as the register itself.
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      unit_en <= 1'b0;
    end else if (AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.byteenable[0]
                 && AVS_REQ.address[5:2] == IDX_UNIT_CONTROL) begin
      unit_en <= AVS_REQ.writedata[UNIT_ENABLE_BIT];
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  chk_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
    else $error("waitrequest low in first request cycle");
  chk_wait_once: assert property (req && AVS_WAITREQUEST |=> !req || !AVS_WAITREQUEST)
    else $error("waitrequest high longer than one cycle");
  chk_wait_idle: assert property (!req |-> !AVS_WAITREQUEST)
    else $error("waitrequest high without request");
  chk_rdata_stand: assert property (!req |=> $stable(AVS_READDATA))
    else $error("read data changed while idle");
  chk_rdata_upper: assert property (AVS_READDATA[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  chk_unit_off_oe: assert property (!unit_en |-> PIN_OE == 2'b00)
    else $error("pin enable while unit disabled");
  chk_unit_off_event: assert property (!unit_en [*3] |-> EVENT_OUT == 2'b00)
    else $error("event output while unit disabled");
  chk_pin_gate: assert property (PIN_OUT == (EVENT_OUT & PIN_OE))
    else $error("pin output differs from gated event");
  cover property (AVS_REQ.write && !AVS_WAITREQUEST);
  cover property (PIN_OE[0] && EVENT_OUT[0]);
  cover property (STANDBY && EVENT_OUT[1]);
endmodule

bind clu_top clu_top_assertions chk_u (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_REQ(AVS_REQ), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .STANDBY(STANDBY), .EVENT_OUT(EVENT_OUT),
  .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE));

// ### tb/clu_src_model.sv
`timescale 1ns/1ps
module clu_src_model
  import clu_pkg::*;
(
  // Clock and reset.
  input  wire logic            clk,
  input  wire logic            rst,
  // Commands from the bench.
  input  wire logic [1:0][2:0] pin_cmd,
  input  wire logic [1:0]      ev_cmd,
  // Lines into the unit.
  output logic [1:0][2:0]      pin_line,
  output logic [1:0]           ev_line,
  output logic [8:0]           periph_line
);
  // Unselected peripheral lines change every cycle, so a wrong source select never reads as a steady level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_line <= '0;
      ev_line <= '0;
      periph_line <= 9'h0AA;
    end else begin
      pin_line <= pin_cmd;
      ev_line <= ev_cmd;
      periph_line <= {periph_line[7:0], ~periph_line[8]};
    end
  end
endmodule

// ### tb/clu_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end
module clu_top_tb
  import clu_pkg::*;
;
  localparam logic [7:0] TRUTH_A = 8'hB4;
  localparam logic [3:0] E_PAT   = 4'h9;
  localparam logic [3:0] X_PAT   = 4'hB;
  logic            CLOCK   = 1'b0;
  logic            SYS_RST = 1'b1;
  logic            STANDBY = 1'b0;
  clu_avs_req_t    avs_req = '0;
  logic [1:0][2:0] pin_cmd = '0;
  logic [1:0]      ev_cmd  = '0;
  logic [1:0][2:0] pin_line;
  logic [1:0]      ev_line;
  logic [8:0]      periph_line;
  logic [31:0]     rdata;
  logic            wait_req;
  logic [1:0]      ev_out;
  logic [1:0]      pin_out;
  logic [1:0]      pin_oe;
  int              err_count       = 0;
  int              samples_checked = 0;
  int              cycles          = 0;

  always #5 CLOCK = ~CLOCK;

  clu_src_model src_u (.clk(CLOCK), .rst(SYS_RST), .pin_cmd(pin_cmd), .ev_cmd(ev_cmd),
    .pin_line(pin_line), .ev_line(ev_line), .periph_line(periph_line));
  clu_top dut_u (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_REQ(avs_req), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wait_req), .PIN_IN(pin_line), .EVENT_IN(ev_line), .PERIPH_IN(periph_line),
    .STANDBY(STANDBY), .EVENT_OUT(ev_out), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

  task end_sim;
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      end_sim;
    end
  end

  task waitc(input int n);
    repeat (n) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask

  // The request stands until waitrequest is seen low at a rising edge; read data are taken at that edge.
  // A slave that never answers is caught by the cycle ceiling, not here.
  task bus(input logic wr, input logic [3:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge CLOCK);
    avs_req.read <= ~wr;
    avs_req.write <= wr;
    avs_req.address <= {idx, 2'h0};
    avs_req.writedata <= {24'h00_0000, wd};
    avs_req.byteenable <= 4'hF;
    do begin
      @(posedge CLOCK);
    end while (wait_req !== 1'b0);
    rd = rdata[7:0];
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask

  task wr(input logic [3:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, d);
  endtask

  task rdv(input logic [3:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask

  task cfg(input logic [3:0] ia, input logic [7:0] a, b, c, t);
    wr(ia, 8'h00);
    wr(ia + 4'h1, b);
    wr(ia + 4'h2, c);
    wr(ia + 4'h3, t);
    wr(ia, a);
  endtask

  task t_regs;
    logic [7:0] d;
    rdv(IDX_UNIT_CONTROL, d);
    `CHK("unit_control reset", REG_RESET, d);
    wr(4'h2, 8'hFF);
    rdv(4'h2, d);
    `CHK("unmapped read", 8'h00, d);
    wr(IDX_UNIT_CONTROL, 8'hFF);
    rdv(IDX_UNIT_CONTROL, d);
    `CHK("unit_control bits", 8'h41, d);
  endtask

  task t_truth;
    cfg(IDX_TABLE0_CONTROL_A, 8'h09, 8'h55, 8'h05, TRUTH_A);
    cfg(IDX_TABLE1_CONTROL_A, 8'h01, 8'h03, 8'h00, 8'hAA);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLOCK);
      pin_cmd[0] <= 3'(i);
      ev_cmd[0] <= i[0];
      waitc(4);
      `CHK("table0 out", TRUTH_A[i], ev_out[0]);
      `CHK("pin out", {1'b0, TRUTH_A[i]}, pin_out);
      `CHK("event path", i[0], ev_out[1]);
    end
    wr(IDX_UNIT_CONTROL, 8'h00);
    cfg(IDX_TABLE1_CONTROL_A, 8'h41, 8'h00, 8'h05, 8'hF0);
    wr(IDX_UNIT_CONTROL, 8'h01);
    @(posedge CLOCK);
    pin_cmd[1] <= 3'h4;
    waitc(6);
    `CHK("masked input two", 1'b0, ev_out[1]);
    wr(IDX_UNIT_CONTROL, 8'h00);
    cfg(IDX_TABLE1_CONTROL_A, 8'h01, 8'h05, 8'h00, 8'hAA);
    wr(IDX_UNIT_CONTROL, 8'h01);
    pin_cmd <= '0;
  endtask

  task t_filter;
    int d;
    for (int f = 1; f < 3; f++) begin
      cfg(IDX_TABLE0_CONTROL_A, 8'h01 | 8'(f << 4), 8'h05, 8'h00, 8'hAA);
      @(posedge CLOCK);
      pin_cmd[0] <= 3'h1;
      d = 0;
      do begin
        @(negedge CLOCK);
        d++;
      end while (ev_out[0] !== 1'b1 && d < 20);
      `CHK("filter delay", (f == 1) ? 5 : 7, d);
      wr(IDX_TABLE0_CONTROL_A, 8'h00);
      waitc(2);
      wr(IDX_TABLE0_CONTROL_A, 8'h01 | 8'(f << 4));
      waitc(1);
      `CHK("filter cleared", 1'b0, ev_out[0]);
      pin_cmd[0] <= 3'h0;
      waitc(10);
    end
  endtask

  task t_edge;
    int n;
    for (int j = 0; j < 2; j++) begin
      cfg(IDX_TABLE0_CONTROL_A, 8'h91, 8'h05, 8'h00, j ? 8'h55 : 8'hAA);
      @(posedge CLOCK);
      pin_cmd[0] <= 3'(1 - j);
      n = 0;
      repeat (15) begin
        @(negedge CLOCK);
        if (ev_out[0] === 1'b1) n++;
      end
      `CHK("edge pulses", 1, n);
    end
    pin_cmd[0] <= 3'h0;
  endtask

  task t_seq;
    logic [7:0] d;
    logic       g;
    cfg(IDX_TABLE0_CONTROL_A, 8'h01, 8'h05, 8'h00, 8'hAA);
    for (int m = 1; m < 5; m++) begin
      wr(IDX_TABLE0_CONTROL_A, 8'h00);
      wr(IDX_SEQUENTIAL_SELECT, 8'(m));
      wr(IDX_TABLE0_CONTROL_A, 8'h01);
      wr(IDX_SEQUENTIAL_SELECT, 8'h00);
      rdv(IDX_SEQUENTIAL_SELECT, d);
      `CHK("seq select held", 8'(m), d);
      g = (m == 1 || m == 3);
      for (int s = 0; s < 4; s++) begin
        @(posedge CLOCK);
        pin_cmd[0][0] <= E_PAT[s];
        pin_cmd[1][0] <= (s == 2) || (g && (s == 0 || s == 3));
        waitc(6);
        `CHK("seq out", X_PAT[s], ev_out[0]);
      end
      // Both latch inputs high would carry into the next mode, and that is forbidden in RS mode.
      pin_cmd[1][0] <= 1'b0;
      wr(IDX_TABLE0_CONTROL_A, 8'h00);
      rdv(IDX_UNIT_STATUS, d);
      `CHK("seq cleared", 1'b0, d[2]);
    end
    wr(IDX_SEQUENTIAL_SELECT, 8'h00);
  endtask

  task t_standby;
    cfg(IDX_TABLE0_CONTROL_A, 8'h11, 8'h05, 8'h00, 8'hAA);
    @(posedge CLOCK);
    pin_cmd <= {3'h1, 3'h1};
    for (int r = 0; r < 2; r++) begin
      wr(IDX_UNIT_CONTROL, r ? 8'h41 : 8'h01);
      waitc(8);
      @(posedge CLOCK);
      STANDBY <= 1'b1;
      waitc(4);
      `CHK("standby forced", 1'(r), ev_out[0]);
      `CHK("plain table runs", 1'b1, ev_out[1]);
      @(posedge CLOCK);
      STANDBY <= 1'b0;
    end
  endtask

  initial begin
    repeat (16) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    t_regs;
    t_truth;
    t_filter;
    t_edge;
    t_seq;
    t_standby;
    end_sim;
  end
endmodule
